// ==== common/hbridge_if.sv ====
// Purpose: carrier between controller end and driver end
// Assumes: one clock, both ends on mclk
// Notes:   sense sample is the digitised current-sense voltage
`timescale 1ns/1ps
`default_nettype none
interface hbridge_if;
	import hbridge_pkg::*;
	logic                    drive_input_a;
	logic                    drive_input_b;
	logic [sample_width-1:0] current_sense_output;
	modport controller (output drive_input_a, output drive_input_b,
		input current_sense_output);
	modport driver (input drive_input_a, input drive_input_b,
		output current_sense_output);
endinterface
`default_nettype wire

// ==== common/hbridge_pkg.sv ====
// Purpose: shared constants and types for the h-bridge decode and stall monitor pair
// Assumes: 200 MHz mclk, 12-bit current-sense samples
// Notes:   long times are module parameters so a simulation can shorten them
`default_nettype none
package hbridge_pkg;
	localparam int unsigned clk_mhz          = 200;
	localparam int unsigned sample_width     = 12;
	// sense samples are 12 bit codes of 0 to 3.3 V; 1 V is about code 0x4d9
	localparam logic [11:0] stall_threshold_default = 12'h4d9;
	localparam int unsigned relay_pulse_ms   = 200;
	localparam int unsigned inrush_ms        = 65;
	localparam int unsigned stall_confirm_ms = 65;
	localparam int unsigned sleep_us         = 1000;
	localparam int unsigned wake_us          = 250;
	localparam int unsigned ms_cycles_per    = clk_mhz * 1000;
	localparam int unsigned relay_pulse_cycles   = relay_pulse_ms * ms_cycles_per;
	localparam int unsigned inrush_cycles        = inrush_ms * ms_cycles_per;
	localparam int unsigned stall_confirm_cycles = stall_confirm_ms * ms_cycles_per;
	localparam int unsigned sleep_cycles         = sleep_us * clk_mhz;
	localparam int unsigned wake_cycles          = wake_us * clk_mhz;
	localparam int unsigned timer_width      = 32;

	// bridge half drive state
	typedef enum logic [1:0] {half_hiz, half_low, half_high} half_type;
	// controller drive commands
	typedef enum logic [2:0] {cmd_coast, cmd_forward, cmd_reverse, cmd_brake,
		cmd_coil1, cmd_coil2} cmd_type;
endpackage

`default_nettype wire

// ==== design/hbridge_controller.sv ====
// Purpose: controller end: drives the two inputs, times relay pulses, watches for stall
// Assumes: current-sense samples are on mclk; one command accepted while idle
// Notes:   threshold should sit between average running and stall sense levels
// Operation
// - both inputs low gives hi-z bridge
// - a low b high: a low, b high
// - a high b low: a high, b low
// - both high brakes; never for dual coil
// - single coil: drive, optional brake, then coast
// - hold each relay state for pulse time
// - compare sense sample against stall threshold
// - ignore overcurrent during inrush window after start
// - stall after threshold exceeded for confirm time
// - threshold between stall and running levels
// - optional startup duty ramp limits inrush
// - sleep after low delay, wake after high
`timescale 1ns/1ps
`default_nettype none
module hbridge_controller
	import hbridge_pkg::*;
#(
	parameter int unsigned pulse_count   = relay_pulse_cycles,
	parameter int unsigned inrush_count  = inrush_cycles,
	parameter int unsigned confirm_count = stall_confirm_cycles
)(
	input  wire logic                    mclk,
	input  wire logic                    reset,
	hbridge_if.controller                link,
	input  wire logic                    cmd_valid,
	input  wire cmd_type                 cmd,
	input  wire logic                    relay_mode,
	input  wire logic                    relay_brake,
	input  wire logic                    ramp_enable,
	input  wire logic [sample_width-1:0] stall_sense_threshold,
	output logic                         busy,
	output logic                         stall
);
	typedef enum logic [1:0] {st_idle, st_pulse, st_brake} state_type;
	state_type              state;
	logic [1:0]             pins;
	logic [timer_width-1:0] pulse_timer;
	logic [timer_width-1:0] inrush_timer;
	logic [timer_width-1:0] confirm_timer;
	logic [7:0]             ramp_duty;
	logic [7:0]             pwm_phase;
	logic                   pwm_on;
	logic                   motor_on;
	logic                   over;
	logic                   dual_coil;
	logic                   brake_next;

	// map command to pin pair; coil commands never give both high
	function automatic logic [1:0] pins_of(input cmd_type c);
		unique case (c)
			cmd_forward: pins_of = 2'b10;
			cmd_reverse: pins_of = 2'b01;
			cmd_brake:   pins_of = 2'b11;
			cmd_coil1:   pins_of = 2'b01;
			cmd_coil2:   pins_of = 2'b10;
			default:     pins_of = 2'b00;
		endcase
	endfunction

	// pulse sequencer for relays, plain hold for motor commands
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			state       <= st_idle;
			pins        <= 2'b00;
			pulse_timer <= 32'h0;
			dual_coil   <= 1'b0;
		end
		else
		begin
			unique case (state)
				st_idle:
				begin
					pulse_timer <= 32'h0;
					if (cmd_valid)
					begin
						pins <= pins_of(cmd);
						dual_coil <= cmd == cmd_coil1 || cmd == cmd_coil2;
						if (relay_mode && cmd != cmd_coast && cmd != cmd_brake)
							state <= st_pulse;
					end
				end
				st_pulse:
				begin
					if (pulse_timer >= pulse_count - 1)
					begin
						pulse_timer <= 32'h0;
						pins        <= brake_next ? 2'b11 : 2'b00;
						state       <= brake_next ? st_brake : st_idle;
					end
					else
						pulse_timer <= pulse_timer + 32'h1;
				end
				st_brake:
				begin
					if (pulse_timer >= pulse_count - 1)
					begin
						pins  <= 2'b00;
						state <= st_idle;
					end
					else
						pulse_timer <= pulse_timer + 32'h1;
				end
			endcase
		end
	end

	// startup duty ramp: duty climbs once per pwm period while motor runs
	always_ff @(posedge mclk)
	begin
		if (reset || !motor_on)
		begin
			pwm_phase <= 8'h0;
			ramp_duty <= 8'h0;
		end
		else
		begin
			pwm_phase <= pwm_phase + 8'h1;
			if (pwm_phase == 8'hff && ramp_duty != 8'hff)
				ramp_duty <= ramp_duty + 8'h1;
		end
	end

	assign motor_on = (pins == 2'b10 || pins == 2'b01) && !relay_mode;
	assign pwm_on   = !ramp_enable || ramp_duty == 8'hff || pwm_phase < ramp_duty;
	assign over     = link.current_sense_output > stall_sense_threshold;
	// both-high would fire both coils of a dual-coil relay, so only single coils brake
	assign brake_next = relay_brake && !dual_coil;

	// drive pins, chopped to coast during the ramp
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			link.drive_input_a <= 1'b0;
			link.drive_input_b <= 1'b0;
			busy               <= 1'b0;
		end
		else
		begin
			link.drive_input_a <= pins[1] & (pwm_on | !motor_on);
			link.drive_input_b <= pins[0] & (pwm_on | !motor_on);
			busy               <= state != st_idle;
		end
	end

	// stall monitor: inrush blanking, confirmation, sticky flag
	always_ff @(posedge mclk)
	begin
		if (reset || !motor_on)
		begin
			inrush_timer  <= 32'h0;
			confirm_timer <= 32'h0;
			stall         <= 1'b0;
		end
		else if (inrush_timer < inrush_count)
			inrush_timer <= inrush_timer + 32'h1;
		else if (!over)
			confirm_timer <= 32'h0;
		else if (confirm_timer >= confirm_count - 1)
			stall <= 1'b1;
		else
			confirm_timer <= confirm_timer + 32'h1;
	end
endmodule // hbridge_controller
`default_nettype wire

// ==== design/hbridge_driver.sv ====
// Purpose: driver end: decodes the two drive inputs into bridge half states, sleep/wake
// Assumes: drive inputs arrive from another chip, so they are synchronised
// Notes:   sense_sample is the analog current mirror as digitised by the bench
`timescale 1ns/1ps
`default_nettype none
module hbridge_driver
	import hbridge_pkg::*;
#(
	parameter int unsigned sleep_count = sleep_cycles,
	parameter int unsigned wake_count  = wake_cycles
)(
	input  wire logic                    mclk,
	input  wire logic                    reset,
	hbridge_if.driver                    link,
	input  wire logic [sample_width-1:0] sense_sample,
	output half_type                     bridge_output_a,
	output half_type                     bridge_output_b,
	output logic                         awake
);
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic       in_a;
	logic       in_b;
	logic [timer_width-1:0] timer;

	assign link.current_sense_output = sense_sample;

	// three-stage synchronisers, change taken when stages two and three agree
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			sync_a <= 3'h0;
			sync_b <= 3'h0;
			in_a   <= 1'b0;
			in_b   <= 1'b0;
		end
		else
		begin
			sync_a <= {sync_a[1:0], link.drive_input_a};
			sync_b <= {sync_b[1:0], link.drive_input_b};
			if (sync_a[1] == sync_a[2])
				in_a <= sync_a[2];
			if (sync_b[1] == sync_b[2])
				in_b <= sync_b[2];
		end
	end

	// sleep after inputs low for sleep delay, wake after any input high for wake delay
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			awake <= 1'b0;
			timer <= 32'h0;
		end
		else if (awake == (in_a | in_b))
			timer <= 32'h0;
		else if (timer >= (awake ? sleep_count : wake_count) - 1)
		begin
			awake <= ~awake;
			timer <= 32'h0;
		end
		else
			timer <= timer + 32'h1;
	end

	// input truth table decode
	always_ff @(posedge mclk)
	begin
		if (reset || !awake)
		begin
			bridge_output_a <= half_hiz;
			bridge_output_b <= half_hiz;
		end
		else
		begin
			unique case ({in_a, in_b})
				2'b00:
				begin
					bridge_output_a <= half_hiz;
					bridge_output_b <= half_hiz;
				end
				2'b01:
				begin
					bridge_output_a <= half_low;
					bridge_output_b <= half_high;
				end
				2'b10:
				begin
					bridge_output_a <= half_high;
					bridge_output_b <= half_low;
				end
				2'b11:
				begin
					bridge_output_a <= half_low;
					bridge_output_b <= half_low;
				end
			endcase
		end
	end
endmodule // hbridge_driver
`default_nettype wire

// ==== tb/hbridge_checker.sv ====
// Purpose: wire-level checks on the controller to driver link
// Assumes: a pin level reaches the bridge outputs within six cycles
// Notes:   counts come from the bench's shortened parameters
`timescale 1ns/1ps
`default_nettype none
module hbridge_checker
	import hbridge_pkg::*;
#(
	parameter int unsigned sleep_count   = 20,
	parameter int unsigned wake_count    = 10,
	parameter int unsigned confirm_count = 30
)(
	input wire logic                    mclk,
	input wire logic                    reset,
	input wire logic                    drive_input_a,
	input wire logic                    drive_input_b,
	input wire logic [sample_width-1:0] current_sense_output,
	input wire logic [sample_width-1:0] stall_sense_threshold,
	input wire half_type                bridge_output_a,
	input wire half_type                bridge_output_b,
	input wire logic                    awake,
	input wire logic                    stall
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	logic [7:0] over;
	logic       any_in;

	// either drive pin high
	assign any_in = drive_input_a | drive_input_b;

	// run of consecutive samples above the threshold, saturating
	always_ff @(posedge mclk)
		if (reset || current_sense_output <= stall_sense_threshold)
			over <= 8'h00;
		else if (over != 8'hff)
			over <= over + 8'h01;

	// a pin pair held long enough to pass the synchroniser
	sequence s_pins(logic a, logic b);
		(drive_input_a == a && drive_input_b == b)[*6];
	endsequence
	sequence s_up;
		awake && $past(awake, 2);
	endsequence

	a_idle_hiz: assert property (s_pins(1'b0, 1'b0) |->
		bridge_output_a == half_hiz && bridge_output_b == half_hiz) else $error("idle not hi-z");
	a_rev_drive: assert property (s_pins(1'b0, 1'b1) ##0 s_up |->
		bridge_output_a == half_low && bridge_output_b == half_high) else $error("bad reverse");
	a_fwd_drive: assert property (s_pins(1'b1, 1'b0) ##0 s_up |->
		bridge_output_a == half_high && bridge_output_b == half_low) else $error("bad forward");
	a_brake_low: assert property (s_pins(1'b1, 1'b1) ##0 s_up |->
		bridge_output_a == half_low && bridge_output_b == half_low) else $error("bad brake");
	a_wake_wait: assert property ($rose(awake) |->
		$past(any_in, wake_count)) else $error("early wake");
	a_sleep_wait: assert property ($fell(awake) |->
		!$past(any_in, sleep_count)) else $error("early sleep");
	a_confirm_time: assert property ($rose(stall) |-> over >= confirm_count)
		else $error("stall too soon");
	a_stall_release: assert property ($fell(stall) |->
		##[0:2] drive_input_a == drive_input_b) else $error("stall dropped while driving");
endmodule // hbridge_checker
`default_nettype wire

// ==== tb/hbridge_input_decode_stall_monitor_test.sv ====
// Purpose: runs the controller and driver ends back to back
// Assumes: shortened counts, checker defaults equal them; duty ramp on in one scenario
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
`define chk(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_errors++; \
	$display("mismatch %s exp %0h got %0h", n, e, s); end end
module hbridge_input_decode_stall_monitor_test;
	import hbridge_pkg::*;
	logic        mclk = 0, reset = 1, cmd_valid = 0, relay_mode = 0, relay_brake = 0;
	logic        busy, stall, awake;
	logic        ramp = 0;
	logic [11:0] sense = 0, thr = 12'h4d9;
	logic [1:0]  pins;
	cmd_type     cmd = cmd_coast;
	half_type    oa, ob;
	int          n_errors = 0, n_checks = 0, cyc = 0;

	hbridge_if link ();
	hbridge_driver #(.sleep_count(20), .wake_count(10)) hbridge_driver_i (.mclk(mclk),
		.reset(reset), .link(link), .sense_sample(sense), .bridge_output_a(oa),
		.bridge_output_b(ob), .awake(awake));
	hbridge_controller #(.pulse_count(50), .inrush_count(40), .confirm_count(30))
		hbridge_controller_i (.mclk(mclk), .reset(reset), .link(link), .cmd_valid(cmd_valid),
		.cmd(cmd), .relay_mode(relay_mode), .relay_brake(relay_brake), .ramp_enable(ramp),
		.stall_sense_threshold(thr), .busy(busy), .stall(stall));
	hbridge_checker hbridge_checker_i (
		.mclk(mclk), .reset(reset), .drive_input_a(link.drive_input_a),
		.drive_input_b(link.drive_input_b), .current_sense_output(link.current_sense_output),
		.stall_sense_threshold(thr), .bridge_output_a(oa), .bridge_output_b(ob),
		.awake(awake), .stall(stall));

	assign pins = {link.drive_input_a, link.drive_input_b};
	// clock and hang guard
	always #2.5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_errors++;
			summarize();
		end
	end

	task automatic step(int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic issue(cmd_type c);
		cmd = c;
		cmd_valid = 1;
		step(1);
		cmd_valid = 0;
	endtask
	// every motor command through to the bridge outputs, then back to sleep
	task automatic t_decode();
		cmd_type    cs [4] = '{cmd_forward, cmd_reverse, cmd_brake, cmd_coast};
		logic [1:0] ep [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
		half_type   ea [4] = '{half_high, half_low, half_low, half_hiz};
		half_type   eb [4] = '{half_low, half_high, half_low, half_hiz};
		foreach (cs[i])
		begin
			issue(cs[i]);
			step(40);
			`chk("pins", ep[i], pins)
			`chk("out_a", ea[i], oa)
			`chk("out_b", eb[i], ob)
			`chk("awake", i < 3, awake)
		end
	endtask
	// inrush blanking, a dip that restarts confirmation, then a sticky stall
	task automatic t_stall();
		sense = 12'h600;
		issue(cmd_forward);
		step(60);
		`chk("stall", 1'b0, stall)
		sense = 12'h100;
		step(5);
		sense = 12'h600;
		step(25);
		`chk("stall", 1'b0, stall)
		step(20);
		`chk("stall", 1'b1, stall)
		sense = 12'h100;
		step(30);
		`chk("stall", 1'b1, stall)
		issue(cmd_coast);
		step(5);
		`chk("stall", 1'b0, stall)
		step(40);
	endtask
	// duty ramp keeps the pins off at first; full drive once the ramp is switched off
	task automatic t_ramp();
		ramp = 1;
		issue(cmd_forward);
		step(100);
		`chk("pins", 2'b00, pins)
		ramp = 0;
		step(2);
		`chk("pins", 2'b10, pins)
		issue(cmd_coast);
		step(40);
	endtask
	// single-coil pulse then brake; dual-coil pulse never brakes; busy drops a command
	task automatic t_relay();
		relay_mode = 1;
		relay_brake = 1;
		issue(cmd_forward);
		step(10);
		issue(cmd_coil2);
		step(30);
		`chk("pins", 2'b10, pins)
		`chk("busy", 1'b1, busy)
		step(30);
		`chk("pins", 2'b11, pins)
		step(40);
		`chk("pins", 2'b00, pins)
		`chk("busy", 1'b0, busy)
		issue(cmd_coil2);
		step(45);
		`chk("pins", 2'b10, pins)
		step(15);
		`chk("pins", 2'b00, pins)
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// main sequence
	initial
	begin
		step(16);
		reset = 0;
		step(4);
		t_decode();
		t_stall();
		t_ramp();
		t_relay();
		summarize();
	end
endmodule // hbridge_input_decode_stall_monitor_test
`default_nettype wire
